// ==== pkg/pif_params.svh ====
// Offsets, field positions, reset values and masks of the peripheral irq block
`ifndef PIF_PARAMS_SVH
`define PIF_PARAMS_SVH
// Register byte offsets
`define PIF_OFF_FLAGS3 8'h00
`define PIF_OFF_EN1 8'h04
`define PIF_OFF_EN2 8'h08
`define PIF_OFF_EN3 8'h0C
`define PIF_OFF_PRIO1 8'h10
`define PIF_OFF_CTRL 8'h14
`define PIF_OFF_STAT 8'h18
// Implemented bit masks
`define PIF_MASK_FLAGS3 8'h7F
`define PIF_MASK_FLAGS3_WR 8'h4F
`define PIF_MASK_EN1 8'h7B
`define PIF_MASK_EN2 8'hCE
`define PIF_MASK_EN3 8'h7F
`define PIF_MASK_PRIO1 8'h7B
// Reset values
`define PIF_RST_EN 8'h00
`define PIF_RST_PRIO1 8'h7B
`define PIF_RST_CTRL 2'h0
// Third group bit positions
`define PIF_BIT_DISPLAY 6
`define PIF_BIT_SER2_RX 5
`define PIF_BIT_SER2_TX 4
`define PIF_BIT_CHARGE 3
`define PIF_BIT_CAPCMP2 2
`define PIF_BIT_CAPCMP1 1
`define PIF_BIT_CALENDAR 0
// Control register fields
`define PIF_CTRL_PRIO_EN 0
`define PIF_CTRL_PERIPH_EN 1
// Bus responses
`define PIF_RESP_OKAY 2'h0
`define PIF_RESP_SLVERR 2'h2
`endif

// ==== pkg/pif_pkg.sv ====
// Types of the peripheral irq block
package pif_pkg;
  // Capture/compare unit operating mode
  typedef enum logic [1:0] {
    PIF_CC_OFF_type_e = 2'h0,
    PIF_CC_CAPTURE = 2'h1,
    PIF_CC_COMPARE = 2'h2,
    PIF_CC_PWM = 2'h3
  } pif_ccmode_type;
  typedef logic [7:0] pif_byte_type;
endpackage

// ==== hw/pif_irq.sv ====
// Peripheral irq flags, enables and priority with AXI4-Lite registers
// Contract
// - Display flag set when all common lines output, type-B non-static only
// - Serial2 rx flag high while rx buffer full, clears on buffer read
// - Serial2 tx flag high while tx buffer empty, clears on write
// - Charge-time flag set on unit event, stays until software clears
// - Capture mode: capcmp flag set on capture, bit 2 and bit 1
// - Compare mode: capcmp flag set on match, software clears
// - PWM mode: capcmp flag never set by hardware
// - Calendar flag set on calendar event, software clears
// - Without priority levels, peripheral group enable gates all requests
// - Priority bits take effect only when priority levels enabled
// - Priority 1 high, 0 low; priority register resets to ones
// - Enable 1 allows, 0 blocks; enables reset to zero
// - Unimplemented bits read zero and ignore writes
// - First group enables at bits 6,5,4,3,1,0
// - Second group enables at bits 7,6,3,2,1
// - Third group enables at the same positions as third flags
// - Serial2 flags read-only; other third flags writable, reset zero
// - Flags set regardless of enables
// - Priority-levels enable lives in control register
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "pif_params.svh"
module pif_irq (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AXI4-Lite write
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Peripheral events, same clock
  input wire logic DISPLAY_DONE,
  input wire logic DISPLAY_TYPE_B,
  input wire logic DISPLAY_NONSTATIC,
  input wire logic SERIAL2_RX_FULL,
  input wire logic SERIAL2_TX_EMPTY,
  input wire logic CHARGE_TIME_EVENT,
  input wire pif_pkg::pif_ccmode_type CAPCMP2_MODE,
  input wire logic CAPCMP2_CAPTURE,
  input wire logic CAPCMP2_MATCH,
  input wire pif_pkg::pif_ccmode_type CAPCMP1_MODE,
  input wire logic CAPCMP1_CAPTURE,
  input wire logic CAPCMP1_MATCH,
  input wire logic CALENDAR_EVENT,
  // First and second group flags kept elsewhere
  input wire logic [7:0] FLAGS1,
  input wire logic [7:0] FLAGS2,
  // Buffer access strobes to the secondary serial port
  output logic SERIAL2_RX_READ,
  output logic SERIAL2_TX_WRITE,
  output logic [7:0] SERIAL2_TX_DATA,
  input wire logic [7:0] SERIAL2_RX_DATA,
  // Requests to the core
  output logic IRQ_HIGH,
  output logic IRQ_LOW
);
  import pif_pkg::*;

  // Serial2 buffer offsets, behind the flag registers
  localparam logic [7:0] OFF_SER2_RX = 8'h1C;
  localparam logic [7:0] OFF_SER2_TX = 8'h20;

  pif_byte_type flags3_q;
  pif_byte_type en1_q, en2_q, en3_q, prio1_q;
  logic [1:0] ctrl_q;
  logic aw_held_q, w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire, rd_fire;
  logic [7:0] wr_addr, wr_byte;
  logic wr_lane0;
  logic [7:0] hw_set, sw_clr;
  logic [7:0] pend1, pend2, pend3;
  logic rx_read_q, tx_write_q;
  logic [7:0] tx_data_q;
  logic [7:0] stat_rd;
  logic rd_ok;
  logic [31:0] rd_val;

  // Known offset check used by both read and write decode
  function automatic logic known_off(input logic [7:0] a);
    known_off = (a == `PIF_OFF_FLAGS3) || (a == `PIF_OFF_EN1) ||
      (a == `PIF_OFF_EN2) || (a == `PIF_OFF_EN3) ||
      (a == `PIF_OFF_PRIO1) || (a == `PIF_OFF_CTRL) ||
      (a == `PIF_OFF_STAT) || (a == OFF_SER2_RX) || (a == OFF_SER2_TX);
  endfunction

  // Write channel capture, address and data in either order
  assign AWREADY = !aw_held_q && !bvalid_q;
  assign WREADY = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_addr = awaddr_q;
  assign wr_byte = wdata_q[7:0];
  assign wr_lane0 = wstrb_q[0];
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (AWVALID && AWREADY) begin
      aw_held_q <= 1'b1;
      awaddr_q <= {AWADDR[7:2], 2'h0};
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (WVALID && WREADY) begin
      w_held_q <= 1'b1;
      wdata_q <= WDATA;
      wstrb_q <= WSTRB;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end
  // Write response, error on unmapped or read-only address
  always_ff @(posedge CLK) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q <= `PIF_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (known_off(wr_addr) && wr_addr != `PIF_OFF_STAT &&
        wr_addr != OFF_SER2_RX) ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;

  // Enables and priority, unimplemented bits masked
  always_ff @(posedge CLK) begin
    if (RST) begin
      en1_q <= `PIF_RST_EN;
      en2_q <= `PIF_RST_EN;
      en3_q <= `PIF_RST_EN;
      prio1_q <= `PIF_RST_PRIO1;
      ctrl_q <= `PIF_RST_CTRL;
    end else if (wr_fire && wr_lane0) begin
      case (wr_addr)
        `PIF_OFF_EN1: en1_q <= wr_byte & `PIF_MASK_EN1;
        `PIF_OFF_EN2: en2_q <= wr_byte & `PIF_MASK_EN2;
        `PIF_OFF_EN3: en3_q <= wr_byte & `PIF_MASK_EN3;
        `PIF_OFF_PRIO1: prio1_q <= wr_byte & `PIF_MASK_PRIO1;
        `PIF_OFF_CTRL: ctrl_q <= wr_byte[1:0];
        default: ;
      endcase
    end
  end

  // Hardware set conditions of the third group
  always_comb begin
    hw_set = 8'h00;
    hw_set[`PIF_BIT_DISPLAY] = DISPLAY_DONE && DISPLAY_TYPE_B &&
      DISPLAY_NONSTATIC;
    hw_set[`PIF_BIT_CHARGE] = CHARGE_TIME_EVENT;
    hw_set[`PIF_BIT_CAPCMP2] =
      (CAPCMP2_MODE == PIF_CC_CAPTURE && CAPCMP2_CAPTURE) ||
      (CAPCMP2_MODE == PIF_CC_COMPARE && CAPCMP2_MATCH);
    hw_set[`PIF_BIT_CAPCMP1] =
      (CAPCMP1_MODE == PIF_CC_CAPTURE && CAPCMP1_CAPTURE) ||
      (CAPCMP1_MODE == PIF_CC_COMPARE && CAPCMP1_MATCH);
    hw_set[`PIF_BIT_CALENDAR] = CALENDAR_EVENT;
  end
  // Software clear mask: zero written to a writable flag
  assign sw_clr = (wr_fire && wr_lane0 && wr_addr == `PIF_OFF_FLAGS3) ?
    (~wr_byte & `PIF_MASK_FLAGS3_WR) : 8'h00;

  // Sticky flags, set wins over clear, set without regard to enables
  always_ff @(posedge CLK) begin
    if (RST) begin
      flags3_q <= 8'h00;
    end else begin
      flags3_q <= (flags3_q & ~sw_clr) | hw_set;
      if (wr_fire && wr_lane0 && wr_addr == `PIF_OFF_FLAGS3) begin
        // Software may also set writable flags
        flags3_q <= ((flags3_q & ~sw_clr) |
          (wr_byte & `PIF_MASK_FLAGS3_WR)) | hw_set;
      end
      // Serial2 flags follow buffer state and the buffer access strobes only
      flags3_q[`PIF_BIT_SER2_RX] <= SERIAL2_RX_FULL && !rx_read_q;
      flags3_q[`PIF_BIT_SER2_TX] <= SERIAL2_TX_EMPTY && !tx_write_q;
      flags3_q[7] <= 1'b0;
    end
  end
  // Buffer access strobes to the serial port
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_read_q <= 1'b0;
      tx_write_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else begin
      rx_read_q <= rd_fire && ARADDR[7:2] == OFF_SER2_RX[7:2];
      tx_write_q <= wr_fire && wr_lane0 && wr_addr == OFF_SER2_TX;
      if (wr_fire && wr_lane0 && wr_addr == OFF_SER2_TX) begin
        tx_data_q <= wr_byte;
      end
    end
  end
  assign SERIAL2_RX_READ = rx_read_q;
  assign SERIAL2_TX_WRITE = tx_write_q;
  assign SERIAL2_TX_DATA = tx_data_q;

  // Pending per source, flag and enable
  assign pend1 = FLAGS1 & en1_q;
  assign pend2 = FLAGS2 & en2_q;
  assign pend3 = flags3_q & en3_q;
  // Request routing to the core
  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ_HIGH <= 1'b0;
      IRQ_LOW <= 1'b0;
    end else if (ctrl_q[`PIF_CTRL_PRIO_EN]) begin
      // Priority used only here; unlisted groups go high
      IRQ_HIGH <= |(pend1 & prio1_q) || |pend2 || |pend3;
      IRQ_LOW <= |(pend1 & ~prio1_q);
    end else begin
      IRQ_HIGH <= ctrl_q[`PIF_CTRL_PERIPH_EN] &&
        (|pend1 || |pend2 || |pend3);
      IRQ_LOW <= 1'b0;
    end
  end

  // Read status: request and control snapshot
  assign stat_rd = {4'h0, IRQ_LOW, IRQ_HIGH, ctrl_q};
  assign ARREADY = !rvalid_q;
  assign rd_fire = ARVALID && ARREADY;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = known_off({ARADDR[7:2], 2'h0});
    case ({ARADDR[7:2], 2'h0})
      `PIF_OFF_FLAGS3: rd_val[7:0] = flags3_q & `PIF_MASK_FLAGS3;
      `PIF_OFF_EN1: rd_val[7:0] = en1_q;
      `PIF_OFF_EN2: rd_val[7:0] = en2_q;
      `PIF_OFF_EN3: rd_val[7:0] = en3_q;
      `PIF_OFF_PRIO1: rd_val[7:0] = prio1_q;
      `PIF_OFF_CTRL: rd_val[1:0] = ctrl_q;
      `PIF_OFF_STAT: rd_val[7:0] = stat_rd;
      OFF_SER2_RX: rd_val[7:0] = SERIAL2_RX_DATA;
      default: rd_val = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PIF_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_ok ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  // Checks
  a_flag_set_wins: assert property (@(posedge CLK) disable iff (RST)
    CALENDAR_EVENT |=> flags3_q[`PIF_BIT_CALENDAR])
    else $error("calendar event lost");
  a_charge_sticky: assert property (@(posedge CLK) disable iff (RST)
    flags3_q[`PIF_BIT_CHARGE] && !sw_clr[`PIF_BIT_CHARGE]
    |=> flags3_q[`PIF_BIT_CHARGE])
    else $error("charge flag dropped");
  a_pwm_no_set: assert property (@(posedge CLK) disable iff (RST)
    CAPCMP1_MODE == PIF_CC_PWM && !flags3_q[`PIF_BIT_CAPCMP1] &&
    !(wr_fire && wr_addr == `PIF_OFF_FLAGS3)
    |=> !flags3_q[`PIF_BIT_CAPCMP1])
    else $error("pwm set capcmp1 flag");
  a_capture_sets: assert property (@(posedge CLK) disable iff (RST)
    CAPCMP2_MODE == PIF_CC_CAPTURE && CAPCMP2_CAPTURE
    |=> flags3_q[`PIF_BIT_CAPCMP2])
    else $error("capture not flagged");
  a_compare_sets: assert property (@(posedge CLK) disable iff (RST)
    CAPCMP1_MODE == PIF_CC_COMPARE && CAPCMP1_MATCH
    |=> flags3_q[`PIF_BIT_CAPCMP1])
    else $error("compare not flagged");
  a_display_gate: assert property (@(posedge CLK) disable iff (RST)
    DISPLAY_DONE && DISPLAY_TYPE_B && DISPLAY_NONSTATIC
    |=> flags3_q[`PIF_BIT_DISPLAY])
    else $error("display flag missed");
  a_rx_follows: assert property (@(posedge CLK) disable iff (RST)
    !SERIAL2_RX_FULL |=> !flags3_q[`PIF_BIT_SER2_RX])
    else $error("rx flag without full");
  a_tx_follows: assert property (@(posedge CLK) disable iff (RST)
    SERIAL2_TX_EMPTY && !tx_write_q |=> flags3_q[`PIF_BIT_SER2_TX])
    else $error("tx flag missing");
  a_group_gate: assert property (@(posedge CLK) disable iff (RST)
    !ctrl_q[`PIF_CTRL_PRIO_EN] && !ctrl_q[`PIF_CTRL_PERIPH_EN]
    |=> !IRQ_HIGH && !IRQ_LOW)
    else $error("request without group enable");
  a_unimpl_zero: assert property (@(posedge CLK) disable iff (RST)
    !flags3_q[7] && !en1_q[7] && !en1_q[2] && !prio1_q[2] &&
    !en2_q[0] && en2_q[5:4] == 2'h0)
    else $error("unimplemented bit set");
  a_low_prio: assert property (@(posedge CLK) disable iff (RST)
    ctrl_q[`PIF_CTRL_PRIO_EN] && |(pend1 & ~prio1_q)
    |=> IRQ_LOW)
    else $error("low request missed");
  a_en_block: assert property (@(posedge CLK) disable iff (RST)
    (en1_q == 8'h00) && (en2_q == 8'h00) && (en3_q == 8'h00)
    |=> !IRQ_HIGH && !IRQ_LOW)
    else $error("request while all disabled");
  c_high_req: cover property (@(posedge CLK) IRQ_HIGH);
  c_low_req: cover property (@(posedge CLK) IRQ_LOW);
  c_set_clear: cover property (@(posedge CLK)
    CALENDAR_EVENT && sw_clr[`PIF_BIT_CALENDAR]);
  c_tx_write: cover property (@(posedge CLK) tx_write_q);
endmodule // pif_irq

// ==== verification/pif_ser2_model.sv ====
// Model of the secondary serial port buffers beside the irq block
`timescale 1ns/1ps
module pif_ser2_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic push,
  input wire logic [7:0] push_data,
  // Buffer strobes from the block
  input wire logic rx_read,
  input wire logic tx_write,
  // Buffer state to the block
  output logic rx_full,
  output logic tx_empty,
  output logic [7:0] rx_data
);
  logic [3:0] drain_q;
  // Receive buffer fills on push, empties when read
  always_ff @(posedge clk) begin
    if (rst || rx_read) rx_full <= 1'b0;
    else if (push) rx_full <= 1'b1;
  end
  // Empty buffer churns, so a stale byte never passes as data
  always_ff @(posedge clk) begin
    if (rst) rx_data <= 8'h5A;
    else if (push) rx_data <= push_data;
    else if (!rx_full) rx_data <= ~rx_data;
  end
  // Transmit buffer drains a while after each write
  always_ff @(posedge clk) begin
    if (rst) drain_q <= 4'h0;
    else if (tx_write) drain_q <= 4'hC;
    else if (drain_q != 4'h0) drain_q <= drain_q - 4'h1;
  end
  assign tx_empty = (drain_q == 4'h0);
endmodule // pif_ser2_model

// ==== verification/testbench.sv ====
// Self-checking bench for the peripheral irq block
`timescale 1ns/1ps
`include "pif_params.svh"
module testbench;
  import pif_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, type_b;
  logic nonstat, push, awready, wready, bvalid, arready, rvalid;
  logic rx_read, tx_write, rx_full, tx_empty, irq_h, irq_l;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] wstrb;
  logic [6:0] ev;
  logic [7:0] awaddr, araddr, flags1, flags2, push_data;
  logic [7:0] tx_data, rx_data, rbyte;
  logic [31:0] wdata, rdata;
  pif_ccmode_type cc1, cc2;
  int num_errors = 0;
  int n_compared = 0;
  // Block under test
  pif_irq i_dut (
    .CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .DISPLAY_DONE(ev[4]), .DISPLAY_TYPE_B(type_b),
    .DISPLAY_NONSTATIC(nonstat), .SERIAL2_RX_FULL(rx_full),
    .SERIAL2_TX_EMPTY(tx_empty), .CHARGE_TIME_EVENT(ev[3]),
    .CAPCMP2_MODE(cc2), .CAPCMP2_CAPTURE(ev[2]), .CAPCMP2_MATCH(ev[6]),
    .CAPCMP1_MODE(cc1), .CAPCMP1_CAPTURE(ev[1]), .CAPCMP1_MATCH(ev[5]),
    .CALENDAR_EVENT(ev[0]), .FLAGS1(flags1), .FLAGS2(flags2),
    .SERIAL2_RX_READ(rx_read), .SERIAL2_TX_WRITE(tx_write),
    .SERIAL2_TX_DATA(tx_data), .SERIAL2_RX_DATA(rx_data),
    .IRQ_HIGH(irq_h), .IRQ_LOW(irq_l)
  );
  // Serial buffers on the far side
  pif_ser2_model i_ser2 (
    .clk(clk), .rst(rst), .push(push), .push_data(push_data),
    .rx_read(rx_read), .tx_write(tx_write), .rx_full(rx_full),
    .tx_empty(tx_empty), .rx_data(rx_data)
  );
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Count a byte comparison, report a mismatch
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Register write; ready sampled mid-cycle, released after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, b;
    int n;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 40) begin
      @(negedge clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      if (bvalid) resp = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
    end
    if (!b) begin
      num_errors++;
      $display("ERROR %0t: write response timed out", $time);
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask
  // Register read into rbyte
  task automatic rd(input logic [7:0] a);
    logic ar, v;
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    n = 0;
    while (!v && n < 40) begin
      @(negedge clk);
      ar = arvalid & arready;
      v = rvalid;
      rbyte = rdata[7:0];
      if (rvalid) resp = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      n++;
    end
    if (!v) begin
      num_errors++;
      $display("ERROR %0t: read response timed out", $time);
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Read and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk8(rbyte, e);
  endtask
  // One-cycle peripheral events
  task automatic pulse(input logic [6:0] v);
    ev <= v;
    @(posedge clk);
    ev <= 7'h00;
    repeat (2) @(posedge clk);
  endtask
  // Compare request lines as {low, high}
  task automatic irq_chk(input logic [7:0] e);
    repeat (2) @(negedge clk);
    chk8({6'h0, irq_l, irq_h}, e);
    @(posedge clk);
  endtask
  // Reset values and implemented bits
  task automatic t_regs();
    rc(`PIF_OFF_EN1, 8'h00);
    rc(`PIF_OFF_EN2, 8'h00);
    rc(`PIF_OFF_EN3, 8'h00);
    rc(`PIF_OFF_PRIO1, 8'h7B);
    rc(`PIF_OFF_FLAGS3, 8'h10);
    rc(`PIF_OFF_CTRL, 8'h00);
    wr(`PIF_OFF_EN1, 8'hFF);
    rc(`PIF_OFF_EN1, 8'h7B);
    wr(`PIF_OFF_EN2, 8'hFF);
    rc(`PIF_OFF_EN2, 8'hCE);
    wr(`PIF_OFF_EN3, 8'hFF);
    rc(`PIF_OFF_EN3, 8'h7F);
    wr(`PIF_OFF_PRIO1, 8'h84);
    rc(`PIF_OFF_PRIO1, 8'h00);
    chk8({6'h0, resp}, {6'h0, `PIF_RESP_OKAY});
    wr(`PIF_OFF_STAT, 8'h00);
    chk8({6'h0, resp}, {6'h0, `PIF_RESP_SLVERR});
    rc(8'h40, 8'h00);
    chk8({6'h0, resp}, {6'h0, `PIF_RESP_SLVERR});
    $display("regs done");
  endtask
  // Event flags per mode, software clear, read-only bits
  task automatic t_flags();
    pulse(7'h7F);
    rc(`PIF_OFF_FLAGS3, 8'h19);
    wr(`PIF_OFF_FLAGS3, 8'h00);
    rc(`PIF_OFF_FLAGS3, 8'h10);
    type_b <= 1'b1;
    cc2 <= PIF_CC_CAPTURE;
    cc1 <= PIF_CC_COMPARE;
    pulse(7'h34);
    rc(`PIF_OFF_FLAGS3, 8'h56);
    wr(`PIF_OFF_FLAGS3, 8'hFF);
    rc(`PIF_OFF_FLAGS3, 8'h5F);
    wr(`PIF_OFF_FLAGS3, 8'h00);
    $display("flags done");
  endtask
  // Buffer-driven serial flags
  task automatic t_serial();
    push_data <= 8'hC3;
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    repeat (3) @(posedge clk);
    rc(`PIF_OFF_FLAGS3, 8'h30);
    rc(8'h1C, 8'hC3);
    repeat (3) @(posedge clk);
    rc(`PIF_OFF_FLAGS3, 8'h10);
    wr(8'h20, 8'hA6);
    chk8(tx_data, 8'hA6);
    repeat (2) @(posedge clk);
    rc(`PIF_OFF_FLAGS3, 8'h00);
    repeat (16) @(posedge clk);
    rc(`PIF_OFF_FLAGS3, 8'h10);
    $display("serial done");
  endtask
  // Gating and priority routing of requests
  task automatic t_irq();
    wr(`PIF_OFF_EN3, 8'h01);
    wr(`PIF_OFF_EN1, 8'h00);
    wr(`PIF_OFF_EN2, 8'h00);
    pulse(7'h01);
    irq_chk(8'h00);
    wr(`PIF_OFF_CTRL, 8'h02);
    irq_chk(8'h01);
    wr(`PIF_OFF_CTRL, 8'h01);
    irq_chk(8'h01);
    wr(`PIF_OFF_FLAGS3, 8'h00);
    flags1 <= 8'h01;
    wr(`PIF_OFF_EN1, 8'h01);
    irq_chk(8'h02);
    wr(`PIF_OFF_PRIO1, 8'h01);
    irq_chk(8'h01);
    wr(`PIF_OFF_PRIO1, 8'h00);
    wr(`PIF_OFF_CTRL, 8'h02);
    irq_chk(8'h01);
    wr(`PIF_OFF_EN1, 8'h00);
    irq_chk(8'h00);
    $display("irq done");
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    conclude();
  end
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, push, type_b, ev} = '0;
    {awaddr, araddr, flags1, flags2, push_data, wdata} = '0;
    {nonstat, wstrb, rst} = '1;
    cc1 = PIF_CC_PWM;
    cc2 = PIF_CC_PWM;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_flags();
    t_serial();
    t_irq();
    conclude();
  end
endmodule // testbench
